// ==== verilog/umsb_pkg.sv ====
/*
  Shared constants of the per-channel modem status, scratch, divisor and
  feature control register block: offsets, field positions, reset values,
  oversampling and prescaler counts, and the flow control hysteresis table.
  Assumes nothing of its surroundings; it holds definitions only.
*/
package umsb_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int DIV_W = 16;
  localparam logic [3:0] OFS_DIV_LOW = 4'h0;
  localparam logic [3:0] OFS_DIV_HIGH = 4'h1;
  localparam logic [3:0] OFS_MODEM_STATUS = 4'h6;
  localparam logic [3:0] OFS_SCRATCH = 4'h7;
  localparam logic [3:0] OFS_FEATURE = 4'h8;
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hff;
  localparam logic [7:0] RST_FEATURE = 8'h00;
  localparam logic [7:0] RD_NONE = 8'h00;
  // modem output control bits
  localparam int MOC_DTR = 0;
  localparam int MOC_RTS = 1;
  localparam int MOC_OUT1 = 2;
  localparam int MOC_OUT2 = 3;
  localparam int MOC_LOOP = 4;
  localparam int MOC_PRESCALE = 7;
  localparam int EFR_ENHANCED = 4;
  localparam int LFC_DIV_ACCESS = 7;
  // feature control fields
  localparam int FC_TABLE_HI = 7;
  localparam int FC_TABLE_LO = 6;
  localparam int FC_RS485 = 5;
  localparam int FC_IR_INV = 4;
  localparam int FC_HYST_HI = 3;
  localparam logic [1:0] TABLE_D = 2'h3;
  // status line index: flag bit n, level bit n+4
  localparam int ST_CTS = 0;
  localparam int ST_DSR = 1;
  localparam int ST_RI = 2;
  localparam int ST_CD = 3;
  localparam logic [3:0] OS16_LAST = 4'hf;
  localparam logic [3:0] OS8_LAST = 4'h7;
  localparam logic [1:0] PRE4_LAST = 2'h3;
  localparam logic [1:0] PRE1_LAST = 2'h0;
  // hysteresis in characters, entry 15 first
  localparam logic [15:0][5:0] HYST_TABLE = {
    6'h24, 6'h1c, 6'h14, 6'h0c, 6'h34, 6'h30, 6'h2c, 6'h28,
    6'h20, 6'h18, 6'h10, 6'h08, 6'h08, 6'h06, 6'h04, 6'h00};
endpackage

// ==== verilog/umsb_baud_gen.sv ====
/*
  Baud rate generator: prescaler, 16-bit divisor counter and 8x/16x
  oversampling counter. Assumes a divisor held stable by software between
  reprogrammings; a zero divisor stops all ticks.
*/
`timescale 1ns/10ps
module umsb_baud_gen #(
  parameter int DIV_W = umsb_pkg::DIV_W
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [DIV_W-1:0] i_divisor,
  input wire logic i_prescale4,
  input wire logic i_eight_times_sampling,
  output logic o_sample_tick,
  output logic o_baud_tick
);
  if (DIV_W != umsb_pkg::DIV_W) begin : g_bad_width
    $error("divisor width must match the two divisor bytes");
  end

  typedef struct packed {
    logic [1:0] pre;
    logic [DIV_W-1:0] div;
    logic [3:0] os;
    logic sample;
    logic baud;
  } umsb_baud_type;

  umsb_baud_type s_r;
  umsb_baud_type s_nxt;
  logic [1:0] pre_last;
  logic [3:0] os_last;

  always_comb begin
    pre_last = i_prescale4 ? umsb_pkg::PRE4_LAST : umsb_pkg::PRE1_LAST;
    os_last = i_eight_times_sampling ? umsb_pkg::OS8_LAST
                                     : umsb_pkg::OS16_LAST;
    s_nxt = s_r;
    s_nxt.sample = 1'b0;
    s_nxt.baud = 1'b0;
    if (i_rst || i_divisor == '0) begin
      s_nxt = '0;
    end else if (s_r.pre >= pre_last) begin
      s_nxt.pre = 2'h0;
      if (s_r.div >= i_divisor - 1'b1) begin
        s_nxt.div = '0;
        s_nxt.sample = 1'b1;
        if (s_r.os >= os_last) begin
          s_nxt.os = 4'h0;
          s_nxt.baud = 1'b1;
        end else begin
          s_nxt.os = s_r.os + 4'h1;
        end
      end else begin
        s_nxt.div = s_r.div + 1'b1;
      end
    end else begin
      s_nxt.pre = s_r.pre + 2'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s_r <= s_nxt;
  end

  assign o_sample_tick = s_r.sample;
  assign o_baud_tick = s_r.baud;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_baud_on_sample: assert property (
    o_baud_tick |-> o_sample_tick)
    else $error("baud tick without sample tick");
  a_zero_div_quiet: assert property (
    (i_divisor == '0) [*2] |-> !o_sample_tick)
    else $error("tick with zero divisor");
  a_prescale_gap: assert property (
    (i_prescale4 && $stable(i_divisor)) [*4] ##0 o_sample_tick
    |=> !o_sample_tick [*3])
    else $error("prescaler does not divide by four");
  c_baud_tick: cover property (o_baud_tick);
endmodule

// ==== verilog/umsb_hyst_sel.sv ====
/*
  Flow control hysteresis selector: looks up the programmed code and
  passes the character count on only while trigger table d is chosen.
  Assumes the receive flow control logic reads the registered count.
*/
`timescale 1ns/10ps
module umsb_hyst_sel (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_code,
  input wire logic [1:0] i_table,
  output logic [5:0] o_hysteresis
);
  typedef struct packed {
    logic [5:0] hyst;
  } umsb_hyst_type;

  umsb_hyst_type s_r;
  umsb_hyst_type s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (i_rst || i_table != umsb_pkg::TABLE_D) begin
      s_nxt.hyst = 6'h00;
    end else begin
      s_nxt.hyst = umsb_pkg::HYST_TABLE[i_code];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s_r <= s_nxt;
  end

  assign o_hysteresis = s_r.hyst;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_hyst_gated: assert property (
    i_table != umsb_pkg::TABLE_D |=> o_hysteresis == 6'h00)
    else $error("hysteresis outside table d");
  a_hyst_top: assert property (
    i_table == umsb_pkg::TABLE_D && i_code == 4'hb
    |=> o_hysteresis == 6'h34)
    else $error("code 1011 is not 52 characters");
endmodule

// ==== verilog/umsb_regs.sv ====
/*
  Per-channel modem status, scratch pad, baud divisor and feature control
  registers of one uart channel, with modem change detection, loopback
  routing and rts direction control.
  Assumes a synchronous host register port (one-cycle read/write strobes)
  and that line format, modem output control and enhanced feature
  registers live elsewhere and are presented here as plain inputs.
*/
`timescale 1ns/10ps
module umsb_regs (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  input wire logic [7:0] i_line_format_control,
  input wire logic [7:0] i_modem_output_control,
  input wire logic [7:0] i_enhanced_feature_reg,
  input wire logic i_modem_int_en,
  input wire logic i_eight_times_sampling,
  input wire logic i_cts_n,
  input wire logic i_dsr_n,
  input wire logic i_ring_indicator_n,
  input wire logic i_carrier_detect_n,
  input wire logic i_tx_active,
  input wire logic i_tx_serial,
  input wire logic i_rx_pin,
  input wire logic i_ir_rx,
  output logic o_tx_pin,
  output logic o_rx_serial,
  output logic o_ir_rx,
  output logic o_rts_n,
  output logic o_dtr_n,
  output logic o_modem_irq,
  output logic o_tx_disable,
  output logic o_rx_disable,
  output logic [1:0] o_trig_table,
  output logic [5:0] o_hysteresis,
  output logic o_sample_tick,
  output logic o_baud_tick,
  output logic o_sleep_en
);
  typedef struct packed {
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] scratch;
    logic [7:0] feature;
    logic [3:0] delta;
    logic [3:0] prev;
    logic [7:0] rdata;
  } umsb_regs_type;

  umsb_regs_type s_r;
  umsb_regs_type s_nxt;

  logic loop_on;
  logic enh_on;
  logic div_access;
  logic [3:0] level;
  logic [3:0] events;
  logic [3:0] clr;
  logic [7:0] status_byte;
  logic [7:0] rd_mux;
  logic wr_div_low;
  logic wr_div_high;
  logic wr_status;
  logic rd_status;

  assign loop_on = i_modem_output_control[umsb_pkg::MOC_LOOP];
  assign enh_on = i_enhanced_feature_reg[umsb_pkg::EFR_ENHANCED];
  assign div_access = i_line_format_control[umsb_pkg::LFC_DIV_ACCESS];

  // live status levels, active high
  always_comb begin
    if (loop_on) begin
      level[umsb_pkg::ST_CTS] =
        i_modem_output_control[umsb_pkg::MOC_RTS];
      level[umsb_pkg::ST_DSR] = i_modem_output_control[umsb_pkg::MOC_DTR];
      level[umsb_pkg::ST_RI] = i_modem_output_control[umsb_pkg::MOC_OUT1];
      level[umsb_pkg::ST_CD] = i_modem_output_control[umsb_pkg::MOC_OUT2];
    end else begin
      level[umsb_pkg::ST_CTS] = ~i_cts_n;
      level[umsb_pkg::ST_DSR] = ~i_dsr_n;
      level[umsb_pkg::ST_RI] = ~i_ring_indicator_n;
      level[umsb_pkg::ST_CD] = ~i_carrier_detect_n;
    end
  end

  // change detection against the last sampled level
  always_comb begin
    events[umsb_pkg::ST_CTS] = level[umsb_pkg::ST_CTS]
                               ^ s_r.prev[umsb_pkg::ST_CTS];
    events[umsb_pkg::ST_DSR] = level[umsb_pkg::ST_DSR]
                               ^ s_r.prev[umsb_pkg::ST_DSR];
    // ring pin rising means status level falling
    events[umsb_pkg::ST_RI] = s_r.prev[umsb_pkg::ST_RI]
                              & ~level[umsb_pkg::ST_RI];
    events[umsb_pkg::ST_CD] = level[umsb_pkg::ST_CD]
                              ^ s_r.prev[umsb_pkg::ST_CD];
  end

  assign status_byte = {level, s_r.delta};
  assign wr_div_low = i_wr && div_access
                      && i_addr == umsb_pkg::OFS_DIV_LOW;
  assign wr_div_high = i_wr && div_access
                       && i_addr == umsb_pkg::OFS_DIV_HIGH;
  assign wr_status = i_wr && enh_on
                     && i_addr == umsb_pkg::OFS_MODEM_STATUS;
  assign rd_status = i_rd && i_addr == umsb_pkg::OFS_MODEM_STATUS;
  assign clr = rd_status ? 4'hf : 4'h0;

  always_comb begin
    case (i_addr)
      umsb_pkg::OFS_DIV_LOW: begin
        rd_mux = div_access ? s_r.div_low : umsb_pkg::RD_NONE;
      end
      umsb_pkg::OFS_DIV_HIGH: begin
        rd_mux = div_access ? s_r.div_high : umsb_pkg::RD_NONE;
      end
      umsb_pkg::OFS_MODEM_STATUS: begin
        rd_mux = status_byte;
      end
      umsb_pkg::OFS_SCRATCH: begin
        rd_mux = s_r.scratch;
      end
      umsb_pkg::OFS_FEATURE: begin
        rd_mux = s_r.feature;
      end
      default: begin
        rd_mux = umsb_pkg::RD_NONE;
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = level;
    if (i_rst) begin
      s_nxt.div_low = umsb_pkg::RST_DIV_LOW;
      s_nxt.div_high = umsb_pkg::RST_DIV_HIGH;
      s_nxt.scratch = umsb_pkg::RST_SCRATCH;
      s_nxt.feature = umsb_pkg::RST_FEATURE;
      s_nxt.delta = 4'h0;
      s_nxt.rdata = umsb_pkg::RD_NONE;
    end else begin
      if (wr_div_low) begin
        s_nxt.div_low = i_wdata;
      end
      if (wr_div_high) begin
        s_nxt.div_high = i_wdata;
      end
      // scratch has no reset other than i_rst, so sleep keeps it
      if (i_wr && i_addr == umsb_pkg::OFS_SCRATCH) begin
        s_nxt.scratch = i_wdata;
      end
      if (i_wr && i_addr == umsb_pkg::OFS_FEATURE) begin
        s_nxt.feature = i_wdata;
      end
      s_nxt.delta = s_r.delta & ~clr;
      if (wr_status) begin
        s_nxt.delta[umsb_pkg::ST_CD] = i_wdata[umsb_pkg::ST_CD];
        s_nxt.delta[umsb_pkg::ST_RI] = i_wdata[umsb_pkg::ST_RI];
      end
      // a new event wins over a clearing read
      s_nxt.delta = s_nxt.delta | events;
      if (i_rd) begin
        s_nxt.rdata = rd_mux;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    s_r <= s_nxt;
  end

  umsb_baud_gen #(
    .DIV_W(umsb_pkg::DIV_W)
  ) u_baud (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_divisor({s_r.div_high, s_r.div_low}),
    .i_prescale4(i_modem_output_control[umsb_pkg::MOC_PRESCALE]),
    .i_eight_times_sampling(i_eight_times_sampling),
    .o_sample_tick(o_sample_tick),
    .o_baud_tick(o_baud_tick)
  );

  umsb_hyst_sel u_hyst (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_code(s_r.feature[umsb_pkg::FC_HYST_HI:0]),
    .i_table(s_r.feature[umsb_pkg::FC_TABLE_HI:umsb_pkg::FC_TABLE_LO]),
    .o_hysteresis(o_hysteresis)
  );

  assign o_rdata = s_r.rdata;
  assign o_modem_irq = i_modem_int_en && (s_r.delta != 4'h0);
  assign o_tx_disable = s_r.delta[umsb_pkg::ST_CD];
  assign o_rx_disable = s_r.delta[umsb_pkg::ST_RI];
  assign o_trig_table =
    s_r.feature[umsb_pkg::FC_TABLE_HI:umsb_pkg::FC_TABLE_LO];
  // loopback keeps the line idle and feeds tx back to rx
  assign o_tx_pin = loop_on ? 1'b1 : i_tx_serial;
  assign o_rx_serial = loop_on ? i_tx_serial : i_rx_pin;
  assign o_ir_rx = i_ir_rx ^ s_r.feature[umsb_pkg::FC_IR_INV];
  assign o_rts_n = s_r.feature[umsb_pkg::FC_RS485]
                   ? ~i_tx_active
                   : ~i_modem_output_control[umsb_pkg::MOC_RTS];
  assign o_dtr_n = ~i_modem_output_control[umsb_pkg::MOC_DTR];
  assign o_sleep_en = enh_on;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_cts_level: assert property (
    i_rd && i_addr == umsb_pkg::OFS_MODEM_STATUS
    |=> o_rdata[4] == $past(loop_on
        ? i_modem_output_control[umsb_pkg::MOC_RTS] : ~i_cts_n))
    else $error("cts status bit wrong");
  a_cd_change: assert property (
    !loop_on && $past(!loop_on) && $changed(i_carrier_detect_n)
    |=> o_tx_disable)
    else $error("carrier change not flagged");
  a_ri_edge: assert property (
    !loop_on && $past(!loop_on) && $fell(i_ring_indicator_n)
    && !s_r.delta[umsb_pkg::ST_RI] && !wr_status
    |=> !s_r.delta[umsb_pkg::ST_RI])
    else $error("ring falling edge flagged");
  a_ri_rise: assert property (
    !loop_on && $past(!loop_on) && $rose(i_ring_indicator_n)
    |=> o_rx_disable)
    else $error("ring rising edge not flagged");
  a_dsr_irq: assert property (
    !loop_on && $past(!loop_on) && $changed(i_dsr_n) && i_modem_int_en
    ##1 i_modem_int_en |-> o_modem_irq)
    else $error("dsr change gives no interrupt");
  a_cts_flag: assert property (
    !loop_on && $past(!loop_on) && $changed(i_cts_n)
    |=> s_r.delta[umsb_pkg::ST_CTS])
    else $error("cts change not flagged");
  a_flag_guard: assert property (
    i_wr && i_addr == umsb_pkg::OFS_MODEM_STATUS && !enh_on
    && s_r.delta[3:2] == 2'b00 && events[3:2] == 2'b00
    |=> s_r.delta[3:2] == 2'b00)
    else $error("flags written without enhanced enable");
  a_div_guard: assert property (
    i_wr && !div_access && i_addr == umsb_pkg::OFS_DIV_LOW
    |=> $stable(s_r.div_low))
    else $error("divisor written without access bit");
  a_read_clear: assert property (
    rd_status && events == 4'h0 && !wr_status |=> s_r.delta == 4'h0)
    else $error("status read did not clear flags");
  a_rts_dir: assert property (
    s_r.feature[umsb_pkg::FC_RS485] |-> o_rts_n == !i_tx_active)
    else $error("rts not following transmitter");
  a_spr_write: assert property (
    i_wr && i_addr == umsb_pkg::OFS_SCRATCH ##1 !i_wr
    ##1 i_rd && i_addr == umsb_pkg::OFS_SCRATCH && !i_wr
    |=> o_rdata == $past(i_wdata, 3))
    else $error("scratch readback mismatch");
  a_scratch_keep: assert property (
    !(i_wr && i_addr == umsb_pkg::OFS_SCRATCH) |=> $stable(s_r.scratch))
    else $error("scratch changed without a write");
  a_feature_keep: assert property (
    !(i_wr && i_addr == umsb_pkg::OFS_FEATURE) |=> $stable(s_r.feature))
    else $error("feature changed without a write");
  a_table_follow: assert property (
    i_wr && i_addr == umsb_pkg::OFS_FEATURE
    |=> o_trig_table == $past(i_wdata[7:6]))
    else $error("trigger table not taken from write");
  a_div_high_guard: assert property (
    i_wr && !div_access && i_addr == umsb_pkg::OFS_DIV_HIGH
    |=> $stable(s_r.div_high))
    else $error("high divisor written without access bit");
  a_div_read_gate: assert property (
    i_rd && !div_access && i_addr[3:1] == 3'h0 |=> o_rdata == 8'h00)
    else $error("divisor readable without access bit");

  // status levels and held flags
  a_status_upper: assert property (
    i_rd && i_addr == umsb_pkg::OFS_MODEM_STATUS && !loop_on
    |=> o_rdata[7:5] == $past(~{i_carrier_detect_n, i_ring_indicator_n,
        i_dsr_n}))
    else $error("status levels not inverted pins");
  a_loop_upper: assert property (
    i_rd && i_addr == umsb_pkg::OFS_MODEM_STATUS && loop_on
    |=> o_rdata[7:5] == $past({i_modem_output_control[3],
        i_modem_output_control[2], i_modem_output_control[0]}))
    else $error("loopback status levels wrong");
  a_cd_hold: assert property (
    s_r.delta[umsb_pkg::ST_CD] && !rd_status && !wr_status
    |=> s_r.delta[umsb_pkg::ST_CD])
    else $error("carrier flag lost without a read");
  a_ri_hold: assert property (
    s_r.delta[umsb_pkg::ST_RI] && !rd_status && !wr_status
    |=> s_r.delta[umsb_pkg::ST_RI])
    else $error("ring flag lost without a read");
  a_irq_off: assert property (
    !i_modem_int_en |-> !o_modem_irq)
    else $error("interrupt while disabled");
  a_irq_level: assert property (
    o_modem_irq |-> s_r.delta != 4'h0)
    else $error("interrupt without a flag");

  // pin routing
  a_tx_loop: assert property (
    loop_on |-> o_tx_pin == 1'b1)
    else $error("tx pin not idle in loopback");
  a_rx_loop: assert property (
    loop_on |-> o_rx_serial == i_tx_serial)
    else $error("rx not fed from tx in loopback");
  a_rx_pass: assert property (
    !loop_on |-> o_rx_serial == i_rx_pin)
    else $error("rx not fed from pin");
  a_ir_invert: assert property (
    s_r.feature[umsb_pkg::FC_IR_INV] |-> o_ir_rx == !i_ir_rx)
    else $error("infrared input not inverted");
  a_ir_plain: assert property (
    !s_r.feature[umsb_pkg::FC_IR_INV] |-> o_ir_rx == i_ir_rx)
    else $error("infrared input inverted");
  a_rts_manual: assert property (
    !s_r.feature[umsb_pkg::FC_RS485]
    |-> o_rts_n == !i_modem_output_control[umsb_pkg::MOC_RTS])
    else $error("rts taken by transmitter");


  c_status_read: cover property (rd_status && s_r.delta != 4'h0);
  c_set_wins: cover property (rd_status && events != 4'h0);
  c_loopback: cover property (loop_on && events != 4'h0);
  c_div_write: cover property (wr_div_high);
endmodule

// ==== verif/umsb_modem_line.sv ====
/*
  Far-side model of the modem status lines of a serial line transceiver:
  drives the four active-low status lines as the bench commands them.
  Assumes commands change at the falling edge; the lines follow one
  cycle later, also at a falling edge, so they never move at the
  sampling edge of the register block.
*/
`timescale 1ns/10ps
module umsb_modem_line (
  input wire logic i_sys_clk,
  input wire logic [3:0] i_assert,
  output logic o_cts_n,
  output logic o_dsr_n,
  output logic o_ring_indicator_n,
  output logic o_carrier_detect_n
);
  logic [3:0] cmd_r;

  initial begin
    cmd_r = 4'h0;
    {o_carrier_detect_n, o_ring_indicator_n, o_dsr_n, o_cts_n} = 4'hf;
  end

  always @(posedge i_sys_clk) begin
    cmd_r <= i_assert;
  end

  // lines always driven by the transceiver, asserted low
  always @(negedge i_sys_clk) begin
    {o_carrier_detect_n, o_ring_indicator_n, o_dsr_n, o_cts_n} <= ~cmd_r;
  end
endmodule

// ==== verif/test_umsb_regs.sv ====
/*
  Self-checking bench of the modem status, scratch, divisor and feature
  control register block, with the modem line model on the far side.
  Assumes the one-cycle host strobes and registered read data of the
  block; inputs change at the falling edge of the clock.
*/
`timescale 1ns/10ps
module test_umsb_regs;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] d;
    logic acc;
    logic [7:0] exp;
  } umsb_row_type;

  logic sys_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [3:0] addr = 4'h0, lines = 4'h5;
  logic [7:0] wdata = 8'h00, lfc = 8'h00, moc = 8'h00, enhanced_feature_reg = 8'h00, rdata;
  logic int_en = 1'b1, eight_x = 1'b0, tx_active = 1'b0;
  logic tx_serial = 1'b1, rx_pin = 1'b1, ir_rx = 1'b0;
  logic cts_n, dsr_n, ri_n, cd_n, tx_pin, rx_serial, ir_out, rts_n, dtr_n;
  logic irq, tx_dis, rx_dis, s_tick, b_tick, sleep_en;
  logic [1:0] trig;
  logic [5:0] hyst;
  logic [7:0] d, e;
  int n, n_fail = 0, n_checks = 0;
  logic [5:0] hyst_exp [16] = '{6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10,
    6'h18, 6'h20, 6'h28, 6'h2c, 6'h30, 6'h34, 6'h0c, 6'h14, 6'h1c, 6'h24};
  umsb_row_type rows [8] = '{'{4'h7, 8'h5a, 1'b0, 8'h5a},
    '{4'h7, 8'ha5, 1'b1, 8'ha5}, '{4'h8, 8'h3c, 1'b0, 8'h3c},
    '{4'h0, 8'h34, 1'b1, 8'h34}, '{4'h0, 8'h77, 1'b0, 8'h00},
    '{4'h1, 8'h12, 1'b1, 8'h12}, '{4'h1, 8'h99, 1'b0, 8'h00},
    '{4'hf, 8'h55, 1'b1, 8'h00}};

  always #2 sys_clk = ~sys_clk;

  umsb_modem_line umsb_modem_line_inst (.i_sys_clk(sys_clk),
    .i_assert(lines), .o_cts_n(cts_n), .o_dsr_n(dsr_n),
    .o_ring_indicator_n(ri_n), .o_carrier_detect_n(cd_n));

  umsb_regs umsb_regs_inst (.i_sys_clk(sys_clk), .i_rst(rst),
    .i_addr(addr), .i_wr(wr_en), .i_rd(rd_en), .i_wdata(wdata),
    .o_rdata(rdata), .i_line_format_control(lfc),
    .i_modem_output_control(moc), .i_enhanced_feature_reg(enhanced_feature_reg),
    .i_modem_int_en(int_en), .i_eight_times_sampling(eight_x),
    .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_ring_indicator_n(ri_n),
    .i_carrier_detect_n(cd_n), .i_tx_active(tx_active),
    .i_tx_serial(tx_serial), .i_rx_pin(rx_pin), .i_ir_rx(ir_rx),
    .o_tx_pin(tx_pin), .o_rx_serial(rx_serial), .o_ir_rx(ir_out),
    .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_modem_irq(irq),
    .o_tx_disable(tx_dis), .o_rx_disable(rx_dis), .o_trig_table(trig),
    .o_hysteresis(hyst), .o_sample_tick(s_tick), .o_baud_tick(b_tick),
    .o_sleep_en(sleep_en));

  task automatic end_of_test();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    addr = a;
    wdata = v;
    wr_en = 1'b1;
    @(negedge sys_clk);
    wr_en = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    addr = a;
    rd_en = 1'b1;
    @(negedge sys_clk);
    rd_en = 1'b0;
    v = rdata;
  endtask

  // cycles between two ticks, bounded
  task automatic period(input logic baud, output int p);
    int k;
    k = 0;
    while ((baud ? b_tick : s_tick) !== 1'b1 && k < 500) begin
      @(negedge sys_clk);
      k++;
    end
    @(negedge sys_clk);
    p = 1;
    while ((baud ? b_tick : s_tick) !== 1'b1 && p < 500) begin
      @(negedge sys_clk);
      p++;
    end
    if (k >= 500 || p >= 500) begin
      n_fail++;
      end_of_test();
    end
  endtask

  task automatic tick_check(input logic baud, input logic [7:0] exp);
    period(baud, n);
    period(baud, n);
    check(8'(n), exp);
  endtask

  initial begin
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    lfc = 8'h80;
    rd(4'h6, d);
    check(d, 8'h50);
    rd(4'h0, d);
    check(d, 8'h01);
    rd(4'h1, d);
    check(d, 8'h00);
    rd(4'h7, d);
    check(d, 8'hff);
    rd(4'h8, d);
    check(d, 8'h00);
    foreach (rows[i]) begin
      lfc = {rows[i].acc, 7'h00};
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      check(d, rows[i].exp);
    end
    lfc = 8'h80;
    rd(4'h0, d);
    check(d, 8'h34);
    rd(4'h1, d);
    check(d, 8'h12);
    // trigger tables and hysteresis codes
    for (int t = 0; t < 4; t++) begin
      for (int c = 0; c < 16; c++) begin
        wr(4'h8, {t[1:0], 2'h0, c[3:0]});
        @(negedge sys_clk);
        check({6'h00, trig}, 8'(t));
        check({2'h0, hyst}, t == 3 ? {2'h0, hyst_exp[c]} : 8'h00);
      end
    end
    // direction control and infrared polarity
    wr(4'h8, 8'h30);
    moc = 8'h00;
    tx_active = 1'b1;
    @(negedge sys_clk);
    check({7'h00, rts_n}, 8'h00);
    check({7'h00, ir_out}, 8'h01);
    tx_active = 1'b0;
    @(negedge sys_clk);
    check({7'h00, rts_n}, 8'h01);
    wr(4'h8, 8'h00);
    moc = 8'h02;
    tx_active = 1'b1;
    @(negedge sys_clk);
    check({7'h00, rts_n}, 8'h00);
    check({7'h00, ir_out}, 8'h00);
    tx_active = 1'b0;
    moc = 8'h00;
    // change detection on each line, both directions
    lines = 4'h0;
    repeat (3) @(negedge sys_clk);
    rd(4'h6, d);
    for (int i = 0; i < 4; i++) begin
      for (int v = 1; v >= 0; v--) begin
        lines[i] = v[0];
        repeat (3) @(negedge sys_clk);
        e = 8'h00;
        e[i + 4] = v[0];
        e[i] = (i != 2) || (v == 0);
        check({7'h00, irq}, {7'h00, e[i]});
        check({6'h00, tx_dis, rx_dis}, {6'h00, e[3:2]});
        rd(4'h6, d);
        check(d, e);
        check({7'h00, irq}, 8'h00);
      end
    end
    int_en = 1'b0;
    lines = 4'h1;
    repeat (3) @(negedge sys_clk);
    check({7'h00, irq}, 8'h00);
    rd(4'h6, d);
    check(d, 8'h11);
    int_en = 1'b1;
    lines = 4'h0;
    repeat (3) @(negedge sys_clk);
    rd(4'h6, d);
    // flag writes gated by enhanced enable
    wr(4'h6, 8'h0c);
    rd(4'h6, d);
    check(d, 8'h00);
    enhanced_feature_reg = 8'h10;
    wr(4'h6, 8'h0f);
    rd(4'h6, d);
    check(d, 8'h0c);
    check({7'h00, sleep_en}, 8'h01);
    enhanced_feature_reg = 8'h00;
    // loopback ignores the pins
    lines = 4'hf;
    moc = 8'h12;
    tx_serial = 1'b0;
    repeat (3) @(negedge sys_clk);
    check({6'h00, tx_pin, rx_serial}, 8'h02);
    rd(4'h6, d);
    rd(4'h6, d);
    check(d, 8'h10);
    moc = 8'h01;
    tx_serial = 1'b1;
    @(negedge sys_clk);
    check({6'h00, dtr_n, rx_serial}, 8'h01);
    rd(4'h6, d);
    rd(4'h6, d);
    check(d, 8'hf0);
    // baud generator
    moc = 8'h00;
    wr(4'h0, 8'h03);
    wr(4'h1, 8'h00);
    tick_check(1'b0, 8'h03);
    tick_check(1'b1, 8'h30);
    moc = 8'h80;
    tick_check(1'b0, 8'h0c);
    moc = 8'h00;
    eight_x = 1'b1;
    tick_check(1'b1, 8'h18);
    // reset in mid-run with carrier and cts asserted
    lines = 4'h9;
    repeat (3) @(negedge sys_clk);
    wr(4'h7, 8'h00);
    rst = 1'b1;
    @(negedge sys_clk);
    rst = 1'b0;
    rd(4'h6, d);
    check(d, 8'h90);
    rd(4'h7, d);
    check(d, 8'hff);
    rd(4'h0, d);
    check(d, 8'h01);
    end_of_test();
  end
endmodule
